// ### verilog/tws_defines.svh
// offsets, field positions, reset values and timing counts of the two-wire serial port
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH

// register offsets on the user port
`define TWS_OFS_SHIFT 3'h0
`define TWS_OFS_MODE 3'h1
`define TWS_OFS_BUSCTL 3'h2
`define TWS_OFS_OWN 3'h3
`define TWS_OFS_STATUS 3'h4
`define TWS_OFS_PORT 3'h5

// serial_mode_reg fields
`define TWS_MODE_CLK_HI 1
`define TWS_MODE_CLK_LO 0
`define TWS_MODE_LINE_B 2
`define TWS_MODE_ABM 3
`define TWS_MODE_WUP 5
`define TWS_MODE_MATCH 6
`define TWS_MODE_EN 7
`define TWS_MODE_WMASK 8'hBF

// clock select codes
`define TWS_CLK_EXT 2'h0
`define TWS_CLK_TMR 2'h1

// bus_control_reg and status fields
`define TWS_BC_CMD 0
`define TWS_BC_FREE 1
`define TWS_ST_DONE 0
`define TWS_ST_BUSY 1
`define TWS_ST_CLS_LO 2

// reset values
`define TWS_MODE_RST 8'h00
`define TWS_SHIFT_RST 8'hFF
`define TWS_OWN_RST 8'h00

// timing: oscillator divided by 64, toggled every half period
`define TWS_DIV_RATIO 64
`define TWS_HALF_COUNT (`TWS_DIV_RATIO / 2)
`define TWS_FRAME_LAST 3'h7

`endif

// ### verilog/tws_pkg.sv
// types used by the device end of the two-wire serial port
package tws_pkg;

   // transfer state, gray coded along idle -> run -> stopped
   typedef enum logic [1:0]
   {
      tws_idle = 2'b00,
      tws_run = 2'b01,
      tws_stop = 2'b11
   } tws_state_e;

   // class of a received byte in addressed-bus mode
   typedef enum logic [1:0]
   {
      tws_cls_data = 2'h0,
      tws_cls_addr = 2'h1,
      tws_cls_cmd = 2'h2
   } tws_class_e;

endpackage

// ### verilog/tws_link_if.sv
// the shared clock line and two open-drain data lines between both ends
`timescale 1ns/1ps
`default_nettype none

interface tws_link_if;
   // drives from the device end
   logic dev_sck_drv;
   logic dev_sck_oe_n;
   logic dev_da_oe_n;
   logic dev_db_oe_n;
   // drives from the far end
   logic far_sck_drv;
   logic far_sck_oe_n;
   logic far_da_oe_n;
   logic far_db_oe_n;
   // resolved wire levels, pulled up when nobody drives
   logic sck_line;
   logic data_line_a;
   logic data_line_b;

   // clock is pushed by its driver; data lines are wired-and
   assign sck_line = !dev_sck_oe_n ? dev_sck_drv : (!far_sck_oe_n ? far_sck_drv : 1'b1);
   assign data_line_a = dev_da_oe_n & far_da_oe_n;
   assign data_line_b = dev_db_oe_n & far_db_oe_n;

   modport dev
   (
      input sck_line, data_line_a, data_line_b,
      output dev_sck_drv, dev_sck_oe_n, dev_da_oe_n, dev_db_oe_n
   );

   modport far
   (
      input sck_line, data_line_a, data_line_b,
      output far_sck_drv, far_sck_oe_n, far_da_oe_n, far_db_oe_n
   );
endinterface

`default_nettype wire

// ### verilog/tws_far.sv
// far end: a plain shifter on the same two wires, master or slave
`timescale 1ns/1ps
`default_nettype none
`include "tws_defines.svh"

module tws_far #(
   parameter int HALF = `TWS_HALF_COUNT
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // the link
   tws_link_if.far link,
   // user side
   input wire logic master_in,
   input wire logic line_b_in,
   input wire logic start_in,
   input wire logic [7:0] tx_in,
   input wire logic free_in,
   input wire logic cmd_in,
   output logic [7:0] rx_out,
   output logic done_out,
   output logic busy_out
);
   logic sck_s1_q, sck_s2_q, da_s1_q, da_s2_q, db_s1_q, db_s2_q;
   logic sck_q, prev_q, so_q, run_q;
   logic [7:0] sr_q;
   logic [2:0] cnt_q;
   logic [5:0] div_q;
   logic view, rise, fall, din;

   assign view = master_in ? sck_q : sck_s2_q;
   assign rise = view & ~prev_q;
   assign fall = ~view & prev_q;
   assign din = line_b_in ? db_s2_q : da_s2_q;

   // pins are asynchronous here: two flops each
   always_ff @(posedge core_clk_in)
   begin
      sck_s1_q <= link.sck_line;
      sck_s2_q <= sck_s1_q;
      da_s1_q <= link.data_line_a;
      da_s2_q <= da_s1_q;
      db_s1_q <= link.data_line_b;
      db_s2_q <= db_s1_q;
   end

   // clock generation when master, idle high
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         sck_q <= 1'b1;
         div_q <= 6'h00;
      end
      else if (run_q && master_in)
      begin
         div_q <= (div_q == 6'(HALF - 1)) ? 6'h00 : div_q + 6'h01;
         if (div_q == 6'(HALF - 1))
            sck_q <= ~sck_q;
      end
      else
      begin
         sck_q <= 1'b1;
         div_q <= 6'h00;
      end
   end

   // shifting: drive on fall, sample on rise, eight bits
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         run_q <= 1'b0;
         sr_q <= `TWS_SHIFT_RST;
         so_q <= 1'b1;
         cnt_q <= 3'h0;
         prev_q <= 1'b1;
         done_out <= 1'b0;
         rx_out <= 8'h00;
      end
      else
      begin
         prev_q <= view;
         done_out <= 1'b0;
         if (!run_q && start_in)
         begin
            run_q <= 1'b1;
            sr_q <= tx_in;
            cnt_q <= 3'h0;
         end
         else if (!run_q && free_in)
            so_q <= 1'b1;
         else if (!run_q && cmd_in)
            so_q <= 1'b0;
         else if (run_q && fall)
            so_q <= sr_q[7];
         else if (run_q && rise)
         begin
            sr_q <= {sr_q[6:0], din};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == `TWS_FRAME_LAST)
            begin
               run_q <= 1'b0;
               done_out <= 1'b1;
               rx_out <= {sr_q[6:0], din};
            end
         end
      end
   end

   // registered pin drives
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         link.far_sck_drv <= 1'b1;
         link.far_sck_oe_n <= 1'b1;
         link.far_da_oe_n <= 1'b1;
         link.far_db_oe_n <= 1'b1;
         busy_out <= 1'b0;
      end
      else
      begin
         link.far_sck_drv <= sck_q;
         link.far_sck_oe_n <= ~master_in;
         link.far_da_oe_n <= line_b_in | so_q;
         link.far_db_oe_n <= ~line_b_in | so_q;
         busy_out <= run_q;
      end
   end
endmodule

`default_nettype wire

// ### verilog/tws_dev.sv
// device end: register-controlled two-wire serial port with address compare
`timescale 1ns/1ps
`default_nettype none
`include "tws_defines.svh"

module tws_dev #(
   parameter int HALF = `TWS_HALF_COUNT
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // the link
   tws_link_if.dev link,
   // timer output flip-flop, same clock domain
   input wire logic timer_output_clock_in,
   // register port
   input wire logic [2:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // transfer-complete flag
   output logic serial_done_irq_out
);
   tws_pkg::tws_state_e state_q;
   tws_pkg::tws_class_e class_q;
   logic sck_s1_q, sck_s2_q, da_s1_q, da_s2_q, db_s1_q, db_s2_q;
   logic [7:0] mode_q;
   logic [7:0] shift_q;
   logic [7:0] own_q;
   logic [1:0] trig_q;
   logic [1:0] sig_q;
   logic [2:0] cnt_q;
   logic [5:0] div_q;
   logic port_latch_q, so_q, sck_q, prev_q, din_prev_q, match_q;
   logic [1:0] clk_sel;
   logic serial_enable, ext_clk, line_b, wup_eff, running;
   logic sck_view, rise, fall, din, start, last_bit, wake_hit;
   logic [7:0] shift_nx;

   assign clk_sel = mode_q[`TWS_MODE_CLK_HI:`TWS_MODE_CLK_LO];
   assign serial_enable = mode_q[`TWS_MODE_EN];
   assign ext_clk = (clk_sel == `TWS_CLK_EXT);
   assign line_b = mode_q[`TWS_MODE_LINE_B];
   assign wup_eff = mode_q[`TWS_MODE_WUP] & mode_q[`TWS_MODE_ABM];
   assign running = (state_q == tws_pkg::tws_run);

   // the clock seen by the shifter: own drive or the synchronised pin
   assign sck_view = ext_clk ? sck_s2_q : sck_q;
   assign rise = sck_view & ~prev_q;
   assign fall = ~sck_view & prev_q;
   assign din = line_b ? db_s2_q : da_s2_q;
   assign shift_nx = {shift_q[6:0], din};

   // start needs enable plus a stopped frame or a high clock line
   assign start = wr_in && (addr_in == `TWS_OFS_SHIFT) && serial_enable && !running
      && ((state_q == tws_pkg::tws_stop) || sck_view);
   assign last_bit = running && rise && (cnt_q == `TWS_FRAME_LAST);
   assign wake_hit = (class_q == tws_pkg::tws_cls_addr) && (shift_nx == own_q);

   // pins come from another party: two flops before use
   always_ff @(posedge core_clk_in)
   begin
      sck_s1_q <= link.sck_line;
      sck_s2_q <= sck_s1_q;
      da_s1_q <= link.data_line_a;
      da_s2_q <= da_s1_q;
      db_s1_q <= link.data_line_b;
      db_s2_q <= db_s1_q;
   end

   // software-written registers
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         mode_q <= `TWS_MODE_RST;
         own_q <= `TWS_OWN_RST;
         port_latch_q <= 1'b1;
      end
      else if (wr_in)
      begin
         if (addr_in == `TWS_OFS_MODE)
            mode_q <= wdata_in & `TWS_MODE_WMASK;
         if (addr_in == `TWS_OFS_OWN)
            own_q <= wdata_in;
         if (addr_in == `TWS_OFS_PORT)
            port_latch_q <= wdata_in[0];
      end
   end

   // trigger bits live one cycle, then clear themselves; other bits are not stored
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         trig_q <= 2'h0;
      else if (wr_in && (addr_in == `TWS_OFS_BUSCTL))
         trig_q <= {wdata_in[`TWS_BC_FREE], wdata_in[`TWS_BC_CMD]};
      else
         trig_q <= 2'h0;
   end

   // transfer state
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         state_q <= tws_pkg::tws_idle;
      else if (!serial_enable)
         state_q <= tws_pkg::tws_idle;
      else
      begin
         case (state_q)
            tws_pkg::tws_idle,
            tws_pkg::tws_stop:
               if (start)
                  state_q <= tws_pkg::tws_run;
            tws_pkg::tws_run:
               if (last_bit)
                  state_q <= tws_pkg::tws_stop;
            default:
               state_q <= tws_pkg::tws_idle;
         endcase
      end
   end

   // bit counter, cleared at start, eight rising edges per frame
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         cnt_q <= 3'h0;
      else if (start)
         cnt_q <= 3'h0;
      else if (running && rise)
         cnt_q <= cnt_q + 3'h1;
   end

   // shift register: loaded by software, sampled on rising edges only while running
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         shift_q <= `TWS_SHIFT_RST;
      else if (wr_in && (addr_in == `TWS_OFS_SHIFT) && !running)
         shift_q <= wdata_in;
      else if (running && rise)
         shift_q <= shift_nx;
   end

   // output latch: triggers when idle, next MSB on each falling edge
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         so_q <= 1'b1;
      else if (running && fall)
         so_q <= shift_q[7];
      else if (!running && trig_q[1])
         so_q <= 1'b1;
      else if (!running && trig_q[0])
         so_q <= 1'b0;
   end

   // half-period divider for the oscillator source
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in || start || !running)
         div_q <= 6'h00;
      else if (div_q == 6'(HALF - 1))
         div_q <= 6'h00;
      else
         div_q <= div_q + 6'h01;
   end

   // serial clock drive; idles at the port latch so software can shape it
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         sck_q <= 1'b1;
      else if (!running)
         sck_q <= port_latch_q;
      else if (clk_sel == `TWS_CLK_TMR)
         sck_q <= timer_output_clock_in;
      else if (!ext_clk && (div_q == 6'(HALF - 1)))
         sck_q <= ~sck_q;
   end

   // edge detector history
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         prev_q <= 1'b1;
         din_prev_q <= 1'b1;
      end
      else
      begin
         prev_q <= sck_view;
         din_prev_q <= din;
      end
   end

   // bus-free and command conditions: data edge while clock high and idle
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         sig_q <= 2'h0;
      else if (last_bit)
         sig_q <= 2'h0;
      else if (!running && sck_view && din && !din_prev_q)
         sig_q[0] <= 1'b1;
      else if (!running && sck_view && !din && din_prev_q)
         sig_q[1] <= 1'b1;
   end

   // byte class, fixed by the shift-register write that starts the frame
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         class_q <= tws_pkg::tws_cls_data;
      else if (start || (!running && !mode_q[`TWS_MODE_ABM]))
      begin
         if (!mode_q[`TWS_MODE_ABM])
            class_q <= tws_pkg::tws_cls_data;
         else if (sig_q[0])
            class_q <= tws_pkg::tws_cls_addr;
         else if (sig_q[1])
            class_q <= tws_pkg::tws_cls_cmd;
         else
            class_q <= tws_pkg::tws_cls_data;
      end
   end

   // address comparator, meaningful only outside a frame
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         match_q <= 1'b0;
      else
         match_q <= (shift_q == own_q);
   end

   // done flag: a new set wins over a clear in the same cycle
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         serial_done_irq_out <= 1'b0;
      else if (last_bit && (!wup_eff || wake_hit))
         serial_done_irq_out <= 1'b1;
      else if (wr_in && (addr_in == `TWS_OFS_STATUS) && wdata_in[`TWS_ST_DONE])
         serial_done_irq_out <= 1'b0;
   end

   // pin drives: open-drain data pulls low only for a zero latch
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         link.dev_sck_drv <= 1'b1;
         link.dev_sck_oe_n <= 1'b1;
         link.dev_da_oe_n <= 1'b1;
         link.dev_db_oe_n <= 1'b1;
      end
      else
      begin
         link.dev_sck_drv <= sck_q;
         link.dev_sck_oe_n <= ext_clk;
         link.dev_da_oe_n <= !(serial_enable && !line_b && !wup_eff && !so_q);
         link.dev_db_oe_n <= !(serial_enable && line_b && !wup_eff && !so_q);
      end
   end

   // read data, one cycle after the strobe
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
         rdata_out <= 8'h00;
      else if (rd_in)
      begin
         case (addr_in)
            `TWS_OFS_SHIFT: rdata_out <= shift_q;
            `TWS_OFS_MODE: rdata_out <= {mode_q[7], match_q, mode_q[5:0]};
            `TWS_OFS_BUSCTL: rdata_out <= {6'h00, trig_q};
            `TWS_OFS_OWN: rdata_out <= own_q;
            `TWS_OFS_STATUS: rdata_out <= {4'h0, class_q, running, serial_done_irq_out};
            `TWS_OFS_PORT: rdata_out <= {7'h00, port_latch_q};
            default: rdata_out <= 8'h00;
         endcase
      end
      else
         rdata_out <= 8'h00;
   end
endmodule

`default_nettype wire

// ### tb/tws_assertions.sv
// concurrent checks on the two-wire link between the device end and the far end
`timescale 1ns/1ps
`default_nettype none

module tws_assertions #(
   parameter int HALF = 32
) (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   // device end drives
   input wire logic dev_sck_drv,
   input wire logic dev_sck_oe_n,
   input wire logic dev_da_oe_n,
   input wire logic dev_db_oe_n,
   // far end drives
   input wire logic far_sck_drv,
   input wire logic far_sck_oe_n,
   input wire logic far_da_oe_n,
   input wire logic far_db_oe_n,
   // resolved lines
   input wire logic sck_line,
   input wire logic data_line_a,
   input wire logic data_line_b
);
   localparam int LOW_MAX = 2 * HALF + 4;
   localparam int GAP = 2 * HALF + 4;
   logic [15:0] hi_cnt_q;
   logic [3:0] fall_cnt_q;
   logic sck_q;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);

   // length of the present high rest; a long rest marks a frame boundary
   always_ff @(posedge core_clk_in)
   begin
      sck_q <= sck_line;
      hi_cnt_q <= (sys_rst_in || !sck_line) ? 16'h0000 : hi_cnt_q + {15'h0000, hi_cnt_q != 16'hFFFF};
   end

   // clock falls since the last boundary, saturating so a runaway stays visible
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in || hi_cnt_q == 16'(GAP))
         fall_cnt_q <= 4'h0;
      else if (sck_q && !sck_line && fall_cnt_q != 4'hF)
         fall_cnt_q <= fall_cnt_q + 4'h1;
   end

   property p_rst_quiet;
      $fell(sys_rst_in) |-> dev_da_oe_n && dev_db_oe_n && dev_sck_oe_n && dev_sck_drv
         && far_da_oe_n && far_db_oe_n && far_sck_oe_n && far_sck_drv;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("lines driven after reset");

   sequence s_back_high;
      ##[1:LOW_MAX] sck_line;
   endsequence
   property p_low_phase;
      $fell(sck_line) |-> s_back_high;
   endproperty
   a_low_phase: assert property (p_low_phase) else $error("clock low too long");

   property p_eight_falls;
      hi_cnt_q == 16'(GAP) |-> fall_cnt_q == 4'h0 || fall_cnt_q == 4'h8;
   endproperty
   a_eight_falls: assert property (p_eight_falls) else $error("frame not eight clocks");

   property p_fall_cap;
      fall_cnt_q <= 4'h8;
   endproperty
   a_fall_cap: assert property (p_fall_cap) else $error("clock ran past eighth bit");

   property p_dev_rise;
      $rose(sck_line) |-> $stable(dev_da_oe_n) && $stable(dev_db_oe_n);
   endproperty
   a_dev_rise: assert property (p_dev_rise) else $error("device data moved at rise");

   property p_far_rise;
      $rose(sck_line) |-> $stable(far_da_oe_n) && $stable(far_db_oe_n);
   endproperty
   a_far_rise: assert property (p_far_rise) else $error("far data moved at rise");

   property p_dev_one_line;
      dev_da_oe_n || dev_db_oe_n;
   endproperty
   a_dev_one_line: assert property (p_dev_one_line) else $error("device pulls both lines");

   property p_far_one_line;
      far_da_oe_n || far_db_oe_n;
   endproperty
   a_far_one_line: assert property (p_far_one_line) else $error("far pulls both lines");

   // the resolved data lines must have settled before either end samples them
   property p_line_rise;
      $rose(sck_line) |-> $stable(data_line_a) && $stable(data_line_b);
   endproperty
   a_line_rise: assert property (p_line_rise) else $error("data line moved at rise");

   // only one end may push the clock line at a time
   property p_one_clock;
      dev_sck_oe_n || far_sck_oe_n;
   endproperty
   a_one_clock: assert property (p_one_clock) else $error("both ends drive clock");
endmodule

`default_nettype wire

// ### tb/two_wire_serial_io_tb_top.sv
// bench: device end and far end joined on one link, driven through both user sides
`timescale 1ns/1ps
`default_nettype none
`include "tws_defines.svh"

module two_wire_serial_io_tb_top;
   localparam int HALF = 8;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [3:0] tcnt = 4'h0;
   logic tmr = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic master = 1'b0;
   logic line_b = 1'b0;
   logic f_start = 1'b0;
   logic [7:0] f_tx = 8'hFF;
   logic f_free = 1'b0;
   logic f_cmd = 1'b0;
   logic [7:0] rdata;
   logic irq;
   logic [7:0] f_rx;
   logic f_done;
   logic f_busy;
   logic [7:0] f_got = 8'h00;
   int f_cnt = 0;
   int f_seen = 0;
   int n_errors = 0;
   int checked = 0;
   logic [7:0] modes [3] = '{8'h82, 8'h83, 8'h81};
   logic [7:0] datas [3] = '{8'hA5, 8'h96, 8'h5A};

   tws_link_if i_tws_link_if ();
   tws_dev #(.HALF(HALF)) i_tws_dev (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .link(i_tws_link_if.dev), .timer_output_clock_in(tmr), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .serial_done_irq_out(irq));
   tws_far #(.HALF(HALF)) i_tws_far (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
      .link(i_tws_link_if.far), .master_in(master), .line_b_in(line_b), .start_in(f_start),
      .tx_in(f_tx), .free_in(f_free), .cmd_in(f_cmd), .rx_out(f_rx), .done_out(f_done),
      .busy_out(f_busy));
   tws_assertions #(.HALF(HALF)) i_tws_assertions (.core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in), .dev_sck_drv(i_tws_link_if.dev_sck_drv),
      .dev_sck_oe_n(i_tws_link_if.dev_sck_oe_n), .dev_da_oe_n(i_tws_link_if.dev_da_oe_n),
      .dev_db_oe_n(i_tws_link_if.dev_db_oe_n), .far_sck_drv(i_tws_link_if.far_sck_drv),
      .far_sck_oe_n(i_tws_link_if.far_sck_oe_n), .far_da_oe_n(i_tws_link_if.far_da_oe_n),
      .far_db_oe_n(i_tws_link_if.far_db_oe_n), .sck_line(i_tws_link_if.sck_line),
      .data_line_a(i_tws_link_if.data_line_a), .data_line_b(i_tws_link_if.data_line_b));

   // 20 MHz clock
   always #25 core_clk_in = ~core_clk_in;

   // timer flip-flop with the same half period as the divided oscillator
   always @(posedge core_clk_in)
   begin
      tcnt <= tcnt + 4'h1;
      tmr <= tcnt[3];
   end

   // far done is a one-cycle pulse, so its byte is caught here
   always @(posedge core_clk_in)
   begin
      if (f_done === 1'b1)
      begin
         f_got <= f_rx;
         f_cnt <= f_cnt + 1;
      end
   end

   task automatic stop_test();
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // every task starts and ends just after a rising edge
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge core_clk_in);
      wr <= 1'b0;
      @(posedge core_clk_in);
      #1;
   endtask

   task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] m,
                         input logic [7:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge core_clk_in);
      rd <= 1'b0;
      #1;
      chk(what, exp, rdata & m);
      @(posedge core_clk_in);
      #1;
   endtask

   task automatic far_go(input logic m, input logic b, input logic [7:0] d);
      master <= m;
      line_b <= b;
      f_tx <= d;
      f_start <= 1'b1;
      @(posedge core_clk_in);
      f_start <= 1'b0;
      @(posedge core_clk_in);
      #1;
   endtask

   // bounded wait for the far end to finish, then a rest long enough to mark the boundary
   task automatic wait_frame();
      int k;
      k = 0;
      while (f_cnt == f_seen && k < 400)
      begin
         @(posedge core_clk_in);
         k++;
      end
      if (f_cnt == f_seen)
         chk("frame end", 8'h01, 8'h00);
      f_seen = f_cnt;
      repeat (24) @(posedge core_clk_in);
      #1;
   endtask

   initial
   begin
      repeat (20000) @(posedge core_clk_in);
      n_errors++;
      stop_test();
   end

   initial
   begin
      repeat (4) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      @(posedge core_clk_in);
      #1;
      rd_chk("mode", `TWS_OFS_MODE, 8'hFF, `TWS_MODE_RST);
      rd_chk("shift", `TWS_OFS_SHIFT, 8'hFF, `TWS_SHIFT_RST);
      rd_chk("own", `TWS_OFS_OWN, 8'hFF, `TWS_OWN_RST);
      rd_chk("status", `TWS_OFS_STATUS, 8'h0F, 8'h00);
      rd_chk("port", `TWS_OFS_PORT, 8'h01, 8'h01);
      rd_chk("unmapped", 3'h7, 8'hFF, 8'h00);
      // enabling after the write must not launch that byte
      reg_wr(`TWS_OFS_MODE, 8'h02);
      reg_wr(`TWS_OFS_SHIFT, 8'h3C);
      // a one written to the match bit must not stick; the comparator still sees 3C against 00
      reg_wr(`TWS_OFS_MODE, 8'hC2);
      rd_chk("match ignored", `TWS_OFS_MODE, 8'hC0, 8'h80);
      repeat (3 * HALF) @(posedge core_clk_in);
      #1;
      rd_chk("late enable", `TWS_OFS_STATUS, 8'h02, 8'h00);
      // device master on each internal clock code, far end receiving
      for (int i = 0; i < 3; i++)
      begin
         reg_wr(`TWS_OFS_MODE, modes[i]);
         reg_wr(`TWS_OFS_OWN, datas[i]);
         reg_wr(`TWS_OFS_STATUS, 8'h01);
         chk("done cleared", 8'h00, {7'h00, irq});
         far_go(1'b0, 1'b0, 8'hFF);
         // the timer source is followed directly, so start inside its high phase
         if (modes[i][1:0] == `TWS_CLK_TMR)
         begin
            while (tcnt !== 4'h7) @(negedge core_clk_in);
            @(posedge core_clk_in);
            #1;
         end
         reg_wr(`TWS_OFS_SHIFT, datas[i]);
         rd_chk("busy", `TWS_OFS_STATUS, 8'h02, 8'h02);
         wait_frame();
         chk("far rx", datas[i], f_got);
         chk("done", 8'h01, {7'h00, irq});
         rd_chk("shift back", `TWS_OFS_SHIFT, 8'hFF, datas[i]);
         rd_chk("match", `TWS_OFS_MODE, 8'h40, 8'h40);
         rd_chk("idle", `TWS_OFS_STATUS, 8'h03, 8'h01);
      end
      // command trigger pulls line a low, bus-free trigger lets it go; both self-clear
      for (int t = 0; t < 2; t++)
      begin
         reg_wr(`TWS_OFS_BUSCTL, t ? 8'h02 : 8'h01);
         repeat (3) @(posedge core_clk_in);
         #1;
         chk("line a", t ? 8'h01 : 8'h00, {7'h00, i_tws_link_if.data_line_a});
         rd_chk("trigger", `TWS_OFS_BUSCTL, 8'h03, 8'h00);
      end
      // far master on line b against the device sending: wired-and reaches both
      reg_wr(`TWS_OFS_MODE, 8'h84);
      reg_wr(`TWS_OFS_OWN, 8'hA5);
      reg_wr(`TWS_OFS_SHIFT, 8'hF0);
      far_go(1'b1, 1'b1, 8'h3C);
      chk("far busy", 8'h01, {7'h00, f_busy});
      wait_frame();
      chk("far idle", 8'h00, {7'h00, f_busy});
      chk("far wired", 8'h30, f_got);
      rd_chk("shift wired", `TWS_OFS_SHIFT, 8'hFF, 8'h30);
      rd_chk("no match", `TWS_OFS_MODE, 8'h40, 8'h00);
      // wake-up slave: a foreign address stays silent, its own address flags done
      reg_wr(`TWS_OFS_MODE, 8'hA8);
      reg_wr(`TWS_OFS_OWN, 8'h42);
      for (int j = 0; j < 2; j++)
      begin
         reg_wr(`TWS_OFS_STATUS, 8'h01);
         line_b <= 1'b0;
         f_cmd <= 1'b1;
         @(posedge core_clk_in);
         f_cmd <= 1'b0;
         repeat (4) @(posedge core_clk_in);
         f_free <= 1'b1;
         @(posedge core_clk_in);
         f_free <= 1'b0;
         repeat (4) @(posedge core_clk_in);
         #1;
         reg_wr(`TWS_OFS_SHIFT, 8'hFF);
         far_go(1'b1, 1'b0, j ? 8'h42 : 8'h13);
         wait_frame();
         chk("wake-up done", j ? 8'h01 : 8'h00, {7'h00, irq});
         rd_chk("class", `TWS_OFS_STATUS, 8'h0C, 8'h04);
      end
      // idle internal clock pin follows the port latch; the run ends while it is low
      // the far end lets go of the clock first so the two ends never fight over it
      master <= 1'b0;
      reg_wr(`TWS_OFS_MODE, 8'h82);
      reg_wr(`TWS_OFS_PORT, 8'h00);
      repeat (2) @(posedge core_clk_in);
      #1;
      chk("clock pin", 8'h00, {7'h00, i_tws_link_if.sck_line});
      stop_test();
   end
endmodule

`default_nettype wire
